// >>> rtl/fpd_pkg.sv
/*
  Shared constants and types for the flash protection and debug configuration block.
  Assumes a 32-bit boot configuration word presented at reset and a 16-bit byte-addressed bus.
*/
package fpd_pkg;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [15:0] REG_DEBUG_PORT_CONTROL     = 16'hF200;
  localparam logic [15:0] REG_DEVICE_IDENTIFICATION  = 16'hF220;
  localparam logic [15:0] REG_SYSTEM_UNLOCK_KEY      = 16'hF230;
  localparam logic [15:0] REG_PROTECTION_CONFIG_WORD = 16'hF240;

  // Configuration word fields
  localparam int unsigned CODE_PROTECT_BIT       = 28;
  localparam int unsigned BOOT_WRITE_PROTECT_BIT = 24;
  localparam int unsigned PAGE_PROTECT_LSB       = 12;
  localparam int unsigned PAGE_PROTECT_W         = 8;
  localparam int unsigned DEBUG_CHANNEL_BIT      = 3;
  localparam int unsigned DEBUG_FIELD_LSB        = 0;

  localparam logic [1:0] DEBUG_CODE_ON  = 2'h2;
  localparam logic [1:0] DEBUG_CODE_OFF = 2'h3;

  // Held until the word is latched: everything protected, debugger off
  localparam logic [31:0] CFG_SAFE_WORD = 32'h0000_0003;

  // Debug port control fields
  localparam int unsigned DPC_SCAN_PORT_BIT   = 3;
  localparam int unsigned DPC_TRACE_BIT       = 2;
  localparam int unsigned DPC_SCAN_DATA_BIT   = 0;
  localparam logic [31:0] DPC_RESET           = 32'h0000_0008;
  localparam logic [31:0] DPC_IMPLEMENTED     = 32'h0000_000D;
  localparam logic [31:0] SYSTEM_KEY_RESET    = 32'h0000_0000;

  // Identification layout
  localparam int unsigned REVISION_LSB = 28;
  localparam int unsigned REVISION_W   = 4;
  localparam int unsigned PART_ID_W    = 28;

  typedef enum logic [1:0] {
    FPD_CFG_LOAD = 2'h1,
    FPD_CFG_HOLD = 2'h2
  } fpd_cfg_state_e;

  typedef enum logic [1:0] {
    FPD_BUS_IDLE = 2'h1,
    FPD_BUS_ACK  = 2'h2
  } fpd_bus_state_e;

endpackage

// >>> rtl/fpd_cfg_if.sv
/*
  Decoded configuration controls passed from the decoder to the top level.
  Assumes one producer and one consumer in the same clock domain.
*/
`timescale 1ns/10ps
interface fpd_cfg_if;
  logic        valid;
  logic [31:0] word;
  logic        code_protect_n;
  logic        boot_write_protect_n;
  logic [7:0]  page_protect_count_inv;
  logic [7:0]  pages_protected;
  logic        debug_channel_select;
  logic [1:0]  debug_field;
  logic        debug_enable;

  modport producer (output valid, word, code_protect_n, boot_write_protect_n,
                    page_protect_count_inv, pages_protected, debug_channel_select,
                    debug_field, debug_enable);
  modport consumer (input valid, word, code_protect_n, boot_write_protect_n,
                    page_protect_count_inv, pages_protected, debug_channel_select,
                    debug_field, debug_enable);
endinterface

// >>> rtl/fpd_cfg_decode.sv
/*
  Latches the protection and debug configuration word once after reset and decodes it.
  Assumes the word input is stable from reset release until the first clock edge after it.
*/
`timescale 1ns/10ps
module fpd_cfg_decode (
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic [31:0] config_word_in,
  fpd_cfg_if.producer      cfg
);

  typedef struct packed {
    fpd_pkg::fpd_cfg_state_e state;
    logic [31:0]             word;
  } fpd_dec_s;

  fpd_dec_s st_reg;
  fpd_dec_s st_next;
  logic [7:0] pwp;

  always_comb begin
    st_next = st_reg;
    case (st_reg.state)
      fpd_pkg::FPD_CFG_LOAD: begin
        st_next.word  = config_word_in;  // see R10
        st_next.state = fpd_pkg::FPD_CFG_HOLD;
      end
      fpd_pkg::FPD_CFG_HOLD: begin
        st_next = st_reg;  // see R10
      end
      default: begin
        st_next.state = fpd_pkg::FPD_CFG_LOAD;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_reg.state <= fpd_pkg::FPD_CFG_LOAD;
      st_reg.word  <= fpd_pkg::CFG_SAFE_WORD;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pwp = st_reg.word[fpd_pkg::PAGE_PROTECT_LSB +: fpd_pkg::PAGE_PROTECT_W];

  assign cfg.valid                  = (st_reg.state == fpd_pkg::FPD_CFG_HOLD);
  assign cfg.word                   = st_reg.word;
  assign cfg.code_protect_n         = st_reg.word[fpd_pkg::CODE_PROTECT_BIT];  // see R1
  assign cfg.boot_write_protect_n   = st_reg.word[fpd_pkg::BOOT_WRITE_PROTECT_BIT];  // see R2
  assign cfg.page_protect_count_inv = pwp;
  // Ones complement gives the protected page count; all ones means none protected
  assign cfg.pages_protected        = ~pwp;  // see R3 see R4
  assign cfg.debug_channel_select   = st_reg.word[fpd_pkg::DEBUG_CHANNEL_BIT];  // see R5
  // Code protection overrides whatever debugger code was programmed
  assign cfg.debug_field = cfg.code_protect_n ?
                           st_reg.word[fpd_pkg::DEBUG_FIELD_LSB +: 2] :
                           fpd_pkg::DEBUG_CODE_OFF;  // see R7
  // Reserved codes fall through to disabled
  assign cfg.debug_enable = cfg.valid && (cfg.debug_field == fpd_pkg::DEBUG_CODE_ON);  // see R6

  default clocking dc @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  property p_page_none;
    cfg.valid && (pwp == 8'hFF) |-> (cfg.pages_protected == 8'h00);
  endproperty
  a_page_none: assert property (p_page_none) else $error("All-ones field protects pages"); // see R4

  property p_page_all;
    cfg.valid && (pwp == 8'h7F) |-> (cfg.pages_protected == 8'h80);
  endproperty
  a_page_all: assert property (p_page_all) else $error("Whole array not protected"); // see R4

  property p_debug_code;
    cfg.debug_enable |-> cfg.code_protect_n && (st_reg.word[1:0] == 2'h2);
  endproperty
  a_debug_code: assert property (p_debug_code) else $error("Debugger on for bad code"); // see R6

  property p_cp_force;
    cfg.valid && !cfg.code_protect_n |-> (cfg.debug_field == 2'h3) && !cfg.debug_enable;
  endproperty
  a_cp_force: assert property (p_cp_force) else $error("Debugger not forced off"); // see R7

  property p_hold;
    cfg.valid |=> cfg.valid && $stable(cfg.word);
  endproperty
  a_hold: assert property (p_hold) else $error("Configuration changed after load"); // see R10

  property p_load_once;
    !cfg.valid |=> cfg.valid && (cfg.word == $past(config_word_in));
  endproperty
  a_load_once: assert property (p_load_once) else $error("Word not latched"); // see R10

  c_debug_on: cover property (cfg.debug_enable);
  c_cp_on: cover property (cfg.valid && !cfg.code_protect_n);

endmodule

// >>> rtl/fpd_top.sv
/*
  Flash protection and debug configuration block with its Avalon-MM register slave.
  Assumes a configuration word stable at reset release and synchronous request inputs.
*/
// Decided for this implementation: the Avalon-MM interface to the registers.
// Behaviour
// (R1) Code-protect bit 28 low refuses external programmer reads and writes of flash.
// (R2) Boot write-protect bit 24 low blocks boot flash writes during execution.
// (R3) Bits 19-12 hold ones complement of protected page count from flash start.
// (R4) All ones protects nothing; 11111110 one page; 01111111 whole array.
// (R5) Channel select bit 3 routes debug to pair two when 1, else one.
// (R6) Debugger enabled only for code 10; codes 11, 01, 00 disable.
// (R7) Code protection forces effective debugger field to 11, debugger off.
// (R8) Programmer writes 0 to bit 31 and 1 to other reserved bits.
// (R9) Unimplemented bits of control, identification and key registers read 0.
// (R10) Configuration word latched at reset, decoded controls held until next reset.
`timescale 1ns/10ps
module fpd_top #(
  parameter logic [3:0]  REVISION_VALUE = 4'h1,        // Arbitrary value
  parameter logic [27:0] PART_ID_VALUE  = 28'h000_0A5C  // Arbitrary value
) (
  input  wire logic        CLK_IN,
  input  wire logic        RST_B_IN,
  input  wire logic [31:0] CONFIG_WORD_IN,
  input  wire logic [15:0] AVS_ADDRESS_IN,
  input  wire logic        AVS_READ_IN,
  input  wire logic        AVS_WRITE_IN,
  input  wire logic [31:0] AVS_WRITEDATA_IN,
  input  wire logic [3:0]  AVS_BYTEENABLE_IN,
  input  wire logic        PROG_REQ_IN,
  input  wire logic        FLASH_WR_REQ_IN,
  input  wire logic        FLASH_WR_BOOT_IN,
  input  wire logic [7:0]  FLASH_WR_PAGE_IN,
  output logic             AVS_WAITREQUEST_OUT,
  output logic [31:0]      AVS_READDATA_OUT,
  output logic             CFG_VALID_OUT,
  output logic             PROG_ACK_OUT,
  output logic             PROG_OK_OUT,
  output logic             PROG_ACCESS_BLOCK_OUT,
  output logic             FLASH_WR_ACK_OUT,
  output logic             FLASH_WR_OK_OUT,
  output logic             BOOT_WRITE_BLOCK_OUT,
  output logic [7:0]       PAGES_PROTECTED_OUT,
  output logic             PROG_PAIR_TWO_SEL_OUT,
  output logic [1:0]       DEBUG_FIELD_OUT,
  output logic             DEBUG_ENABLE_OUT,
  output logic             SCAN_PORT_ENABLE_OUT,
  output logic             TRACE_OUTPUT_ENABLE_OUT,
  output logic             SCAN_DATA_OUT_ENABLE_OUT
);

  typedef struct packed {
    fpd_pkg::fpd_bus_state_e bus_state;
    logic        waitrequest;
    logic [31:0] readdata;
    logic [31:0] debug_port_control;
    logic [31:0] system_unlock_key;
    logic        cfg_valid;
    logic        prog_ack;
    logic        prog_ok;
    logic        prog_block;
    logic        fw_ack;
    logic        fw_ok;
    logic        boot_block;
    logic [7:0]  pages;
    logic        pair_two;
    logic [1:0]  debug_field;
    logic        debug_enable;
  } fpd_top_s;

  fpd_top_s  st_reg;
  fpd_top_s  st_next;
  fpd_cfg_if cfg_bus ();

  logic [31:0] rd_mux;
  logic [31:0] be_mask;
  logic        req;
  logic        page_free;

  fpd_cfg_decode u_decode (
    .clk_in         (CLK_IN),
    .rst_b_in       (RST_B_IN),
    .config_word_in (CONFIG_WORD_IN),
    .cfg            (cfg_bus.producer)
  );

  assign req       = AVS_READ_IN || AVS_WRITE_IN;
  assign be_mask   = {{8{AVS_BYTEENABLE_IN[3]}}, {8{AVS_BYTEENABLE_IN[2]}},
                      {8{AVS_BYTEENABLE_IN[1]}}, {8{AVS_BYTEENABLE_IN[0]}}};
  // Pages below the protected count are locked, counted from the array start
  assign page_free = (FLASH_WR_PAGE_IN >= cfg_bus.pages_protected);  // see R3 see R4

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (AVS_ADDRESS_IN)
      fpd_pkg::REG_DEBUG_PORT_CONTROL: begin
        rd_mux = st_reg.debug_port_control & fpd_pkg::DPC_IMPLEMENTED;  // see R9
      end
      fpd_pkg::REG_DEVICE_IDENTIFICATION: begin
        rd_mux = {REVISION_VALUE, PART_ID_VALUE};
      end
      fpd_pkg::REG_SYSTEM_UNLOCK_KEY: begin
        rd_mux = st_reg.system_unlock_key;
      end
      fpd_pkg::REG_PROTECTION_CONFIG_WORD: begin
        rd_mux = cfg_bus.word;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always_comb begin
    st_next = st_reg;
    // One wait cycle gives a fixed two-cycle access and keeps read data registered
    case (st_reg.bus_state)
      fpd_pkg::FPD_BUS_IDLE: begin
        st_next.waitrequest = 1'b1;
        if (req) begin
          st_next.bus_state   = fpd_pkg::FPD_BUS_ACK;
          st_next.waitrequest = 1'b0;
          st_next.readdata    = AVS_READ_IN ? rd_mux : 32'h0000_0000;
        end
      end
      fpd_pkg::FPD_BUS_ACK: begin
        st_next.bus_state   = fpd_pkg::FPD_BUS_IDLE;
        st_next.waitrequest = 1'b1;
        if (AVS_WRITE_IN) begin
          if (AVS_ADDRESS_IN == fpd_pkg::REG_DEBUG_PORT_CONTROL) begin
            st_next.debug_port_control = ((st_reg.debug_port_control & ~be_mask) |
                                          (AVS_WRITEDATA_IN & be_mask)) &
                                         fpd_pkg::DPC_IMPLEMENTED;  // see R9
          end
          if (AVS_ADDRESS_IN == fpd_pkg::REG_SYSTEM_UNLOCK_KEY) begin
            st_next.system_unlock_key = (st_reg.system_unlock_key & ~be_mask) |
                                        (AVS_WRITEDATA_IN & be_mask);
          end
        end
      end
      default: begin
        st_next.bus_state   = fpd_pkg::FPD_BUS_IDLE;
        st_next.waitrequest = 1'b1;
      end
    endcase

    st_next.cfg_valid    = cfg_bus.valid;
    st_next.prog_ack     = PROG_REQ_IN;
    st_next.prog_ok      = PROG_REQ_IN && cfg_bus.valid && cfg_bus.code_protect_n;  // see R1
    st_next.prog_block   = !cfg_bus.code_protect_n;  // see R1
    st_next.fw_ack       = FLASH_WR_REQ_IN;
    st_next.fw_ok        = FLASH_WR_REQ_IN && cfg_bus.valid &&
                           (FLASH_WR_BOOT_IN ? cfg_bus.boot_write_protect_n  // see R2
                                             : page_free);  // see R3
    st_next.boot_block   = !cfg_bus.boot_write_protect_n;  // see R2
    st_next.pages        = cfg_bus.pages_protected;  // see R4
    st_next.pair_two     = cfg_bus.debug_channel_select;  // see R5
    st_next.debug_field  = cfg_bus.debug_field;  // see R7
    st_next.debug_enable = cfg_bus.debug_enable;  // see R6
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      st_reg.bus_state          <= fpd_pkg::FPD_BUS_IDLE;
      st_reg.waitrequest        <= 1'b1;
      st_reg.readdata           <= 32'h0000_0000;
      st_reg.debug_port_control <= fpd_pkg::DPC_RESET;
      st_reg.system_unlock_key  <= fpd_pkg::SYSTEM_KEY_RESET;
      st_reg.cfg_valid          <= 1'b0;
      st_reg.prog_ack           <= 1'b0;
      st_reg.prog_ok            <= 1'b0;
      st_reg.prog_block         <= 1'b1;
      st_reg.fw_ack             <= 1'b0;
      st_reg.fw_ok              <= 1'b0;
      st_reg.boot_block         <= 1'b1;
      st_reg.pages              <= 8'hFF;
      st_reg.pair_two           <= 1'b0;
      st_reg.debug_field        <= fpd_pkg::DEBUG_CODE_OFF;
      st_reg.debug_enable       <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign AVS_WAITREQUEST_OUT      = st_reg.waitrequest;
  assign AVS_READDATA_OUT         = st_reg.readdata;
  assign CFG_VALID_OUT            = st_reg.cfg_valid;
  assign PROG_ACK_OUT             = st_reg.prog_ack;
  assign PROG_OK_OUT              = st_reg.prog_ok;
  assign PROG_ACCESS_BLOCK_OUT    = st_reg.prog_block;
  assign FLASH_WR_ACK_OUT         = st_reg.fw_ack;
  assign FLASH_WR_OK_OUT          = st_reg.fw_ok;
  assign BOOT_WRITE_BLOCK_OUT     = st_reg.boot_block;
  assign PAGES_PROTECTED_OUT      = st_reg.pages;
  assign PROG_PAIR_TWO_SEL_OUT    = st_reg.pair_two;
  assign DEBUG_FIELD_OUT          = st_reg.debug_field;
  assign DEBUG_ENABLE_OUT         = st_reg.debug_enable;
  assign SCAN_PORT_ENABLE_OUT     = st_reg.debug_port_control[fpd_pkg::DPC_SCAN_PORT_BIT];
  assign TRACE_OUTPUT_ENABLE_OUT  = st_reg.debug_port_control[fpd_pkg::DPC_TRACE_BIT];
  assign SCAN_DATA_OUT_ENABLE_OUT = st_reg.debug_port_control[fpd_pkg::DPC_SCAN_DATA_BIT];

  default clocking dc @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);

  property p_prog_refuse;
    PROG_REQ_IN && !cfg_bus.code_protect_n |=> PROG_ACK_OUT && !PROG_OK_OUT;
  endproperty
  a_prog_refuse: assert property (p_prog_refuse) else $error("Programmer not refused"); // see R1

  property p_prog_allow;
    PROG_REQ_IN && cfg_bus.valid && cfg_bus.code_protect_n |=> PROG_ACK_OUT && PROG_OK_OUT;
  endproperty
  a_prog_allow: assert property (p_prog_allow) else $error("Programmer wrongly refused"); // see R1

  property p_boot_block;
    FLASH_WR_REQ_IN && FLASH_WR_BOOT_IN && !cfg_bus.boot_write_protect_n
      |=> FLASH_WR_ACK_OUT && !FLASH_WR_OK_OUT;
  endproperty
  a_boot_block: assert property (p_boot_block) else $error("Boot write not blocked"); // see R2

  property p_page_block;
    FLASH_WR_REQ_IN && !FLASH_WR_BOOT_IN && (FLASH_WR_PAGE_IN < ~cfg_bus.page_protect_count_inv)
      |=> FLASH_WR_ACK_OUT && !FLASH_WR_OK_OUT;
  endproperty
  a_page_block: assert property (p_page_block) else $error("Protected page written"); // see R3

  property p_pair_select;
    ##1 PROG_PAIR_TWO_SEL_OUT == $past(cfg_bus.word[3]);
  endproperty
  a_pair_select: assert property (p_pair_select) else $error("Wrong debug pair"); // see R5

  property p_unimpl_zero;
    !AVS_WAITREQUEST_OUT && AVS_READ_IN && (AVS_ADDRESS_IN == 16'hF200)
      |-> (AVS_READDATA_OUT[31:4] == 28'h000_0000) && !AVS_READDATA_OUT[1];
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("Unimplemented bit set"); // see R9

  property p_bus_answer;
    req && AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT ##1 AVS_WAITREQUEST_OUT;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("Bus answer timing wrong");

  property p_wait_idle;
    !req |=> AVS_WAITREQUEST_OUT;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("Answer without request");

  property p_write_data;
    !AVS_WAITREQUEST_OUT && AVS_WRITE_IN |-> (AVS_READDATA_OUT == 32'h0000_0000);
  endproperty
  a_write_data: assert property (p_write_data) else $error("Write answer carries data");

  property p_prog_idle;
    !PROG_REQ_IN |=> !PROG_ACK_OUT && !PROG_OK_OUT;
  endproperty
  a_prog_idle: assert property (p_prog_idle) else $error("Programmer grant unasked"); // see R1

  property p_block_out;
    CFG_VALID_OUT |-> (PROG_ACCESS_BLOCK_OUT == !cfg_bus.code_protect_n);
  endproperty
  a_block_out: assert property (p_block_out) else $error("Access block flag wrong"); // see R1

  property p_boot_allow;
    FLASH_WR_REQ_IN && FLASH_WR_BOOT_IN && cfg_bus.valid && cfg_bus.boot_write_protect_n
      |=> FLASH_WR_ACK_OUT && FLASH_WR_OK_OUT;
  endproperty
  a_boot_allow: assert property (p_boot_allow) else $error("Boot write refused"); // see R2

  property p_boot_out;
    CFG_VALID_OUT |-> (BOOT_WRITE_BLOCK_OUT == !cfg_bus.boot_write_protect_n);
  endproperty
  a_boot_out: assert property (p_boot_out) else $error("Boot block flag wrong"); // see R2

  property p_fw_idle;
    !FLASH_WR_REQ_IN |=> !FLASH_WR_ACK_OUT && !FLASH_WR_OK_OUT;
  endproperty
  a_fw_idle: assert property (p_fw_idle) else $error("Write grant unasked"); // see R3

  property p_page_allow;
    FLASH_WR_REQ_IN && !FLASH_WR_BOOT_IN && cfg_bus.valid &&
      (FLASH_WR_PAGE_IN >= ~cfg_bus.page_protect_count_inv)
      |=> FLASH_WR_ACK_OUT && FLASH_WR_OK_OUT;
  endproperty
  a_page_allow: assert property (p_page_allow) else $error("Free page refused"); // see R3

  property p_pages_out;
    CFG_VALID_OUT |-> (PAGES_PROTECTED_OUT == ~cfg_bus.page_protect_count_inv);
  endproperty
  a_pages_out: assert property (p_pages_out) else $error("Page count wrong"); // see R4

  property p_debug_out;
    DEBUG_ENABLE_OUT |-> CFG_VALID_OUT && (DEBUG_FIELD_OUT == 2'h2);
  endproperty
  a_debug_out: assert property (p_debug_out) else $error("Debugger on for bad code"); // see R6

  property p_debug_forced;
    PROG_ACCESS_BLOCK_OUT |-> (DEBUG_FIELD_OUT == 2'h3) && !DEBUG_ENABLE_OUT;
  endproperty
  a_debug_forced: assert property (p_debug_forced) else $error("Debugger not off"); // see R7

  property p_outputs_hold;
    CFG_VALID_OUT |=> CFG_VALID_OUT && $stable(PAGES_PROTECTED_OUT) &&
      $stable(DEBUG_FIELD_OUT) && $stable(PROG_PAIR_TWO_SEL_OUT) && $stable(BOOT_WRITE_BLOCK_OUT);
  endproperty
  a_outputs_hold: assert property (p_outputs_hold) else $error("Controls changed"); // see R10

  c_prog_refused: cover property (PROG_ACK_OUT && !PROG_OK_OUT);
  c_page_refused: cover property (FLASH_WR_ACK_OUT && !FLASH_WR_OK_OUT && !BOOT_WRITE_BLOCK_OUT);
  c_bus_read: cover property (AVS_READ_IN && !AVS_WAITREQUEST_OUT);

endmodule

// >>> tb/fpd_prog_model.sv
/*
  Programmer-side model: composes the configuration word and issues access requests.
  Assumes the bench sets the programmable fields before each reset.
*/
`timescale 1ns/10ps
module fpd_prog_model (
  input  wire logic        clk_in,
  input  wire logic        lock_n_in,
  input  wire logic        boot_n_in,
  input  wire logic [7:0]  pinv_in,
  input  wire logic        chan_in,
  input  wire logic [1:0]  dfield_in,
  output logic [31:0]      word_out,
  output logic             prog_req_out
);
  // Reserved bits: bit 31 written 0, the rest written 1
  assign word_out = {1'h0, 2'h3, lock_n_in, 3'h7, boot_n_in, 4'hF, pinv_in, 8'hFF,
                     chan_in, 1'h1, dfield_in};
  initial prog_req_out = 1'h0;
  // One-cycle request; a held level would count as a second access
  task automatic pulse();
    @(posedge clk_in);
    prog_req_out <= 1'h1;
    @(posedge clk_in);
    prog_req_out <= 1'h0;
  endtask
endmodule

// >>> tb/testbench.sv
/*
  Self-checking bench for the protection and debug configuration block.
  Assumes the programmer model under tb/ and the design under rtl/.
*/
`timescale 1ns/10ps
module testbench;
  localparam logic [3:0]  REV = 4'h3;        // Arbitrary value
  localparam logic [27:0] PID = 28'h0123456; // Arbitrary value
  logic        clk, rst_b, rd, wr, wreq, wboot, lock_n, boot_n, chan, preq;
  logic        wait_o, valid, pack, pok, pblk, wack, wok, bblk, pair, den, scan, trace, sdo;
  logic [1:0]  dfield, dfo;
  logic [3:0]  be, kb;
  logic [7:0]  pinv, wpage, pages;
  logic [15:0] addr;
  logic [31:0] wdata, rdata, word, e_word, key, ek, rv, d;
  integer      seed = 79;
  integer      failures = 0;
  integer      n_checks = 0;
  int          k, n, cnt, pg;
  bit          exp_q[$];

  fpd_prog_model i_fpd_prog_model (.clk_in(clk), .lock_n_in(lock_n), .boot_n_in(boot_n),
    .pinv_in(pinv), .chan_in(chan), .dfield_in(dfield), .word_out(word), .prog_req_out(preq));
  fpd_top #(.REVISION_VALUE(REV), .PART_ID_VALUE(PID)) i_fpd_top (
    .CLK_IN(clk), .RST_B_IN(rst_b), .CONFIG_WORD_IN(word), .AVS_ADDRESS_IN(addr),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(be),
    .PROG_REQ_IN(preq), .FLASH_WR_REQ_IN(wreq), .FLASH_WR_BOOT_IN(wboot),
    .FLASH_WR_PAGE_IN(wpage), .AVS_WAITREQUEST_OUT(wait_o), .AVS_READDATA_OUT(rdata),
    .CFG_VALID_OUT(valid), .PROG_ACK_OUT(pack), .PROG_OK_OUT(pok),
    .PROG_ACCESS_BLOCK_OUT(pblk), .FLASH_WR_ACK_OUT(wack), .FLASH_WR_OK_OUT(wok),
    .BOOT_WRITE_BLOCK_OUT(bblk), .PAGES_PROTECTED_OUT(pages), .PROG_PAIR_TWO_SEL_OUT(pair),
    .DEBUG_FIELD_OUT(dfo), .DEBUG_ENABLE_OUT(den), .SCAN_PORT_ENABLE_OUT(scan),
    .TRACE_OUTPUT_ENABLE_OUT(trace), .SCAN_DATA_OUT_ENABLE_OUT(sdo));

  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  task automatic report_and_stop();
    if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic timeout();
    failures++;
    $display("[FAIL] %0t wait bound used up", $time);
    report_and_stop();
  endtask

  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t register data %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_ctl(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t control %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until waitrequest is sampled low; data taken at that edge
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] dw,
                     input logic [3:0] b, output logic [31:0] q);
    int i;
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdata <= dw;
    be <= b;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (wait_o === 1'h0) break;
    end
    if (i == 20) timeout();
    q = rdata;
    rd <= 1'h0;
    wr <= 1'h0;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'h0, a, 32'h0, 4'h0, q);
    cmp_reg(q, exp);
  endtask

  task automatic fwr(input logic boot, input logic [7:0] p, input logic exp);
    @(posedge clk);
    wreq <= 1'h1;
    wboot <= boot;
    wpage <= p;
    exp_q.push_back(exp);
    @(posedge clk);
    wreq <= 1'h0;
    @(posedge clk);
    cmp_ctl({14'h0, wack, wok}, {14'h0, 1'h1, exp_q.pop_front()});
  endtask

  task automatic chk_dec();
    logic [1:0] ef;
    ef = e_word[28] ? e_word[1:0] : 2'h3;
    cmp_ctl({15'h0, pblk}, {15'h0, ~e_word[28]});
    cmp_ctl({15'h0, bblk}, {15'h0, ~e_word[24]});
    cmp_ctl({8'h0, pages}, {8'h0, ~e_word[19:12]});
    cmp_ctl({15'h0, pair}, {15'h0, e_word[3]});
    cmp_ctl({13'h0, dfo, den}, {13'h0, ef, ef == 2'h2});
  endtask

  task automatic prog_chk();
    i_fpd_prog_model.pulse();
    @(posedge clk);
    cmp_ctl({14'h0, pack, pok}, {14'h0, 1'h1, e_word[28]});
  endtask

  initial begin
    {rst_b, rd, wr, wreq, wboot, wpage, addr, wdata, be} = '0;
    {lock_n, boot_n, chan, dfield, pinv} = '0;
    // Corner page fields first, then random ones; every debugger code with both locks
    for (k = 0; k < 12; k++) begin
      lock_n <= (k % 3) != 0;
      boot_n <= k[0] ^ k[1];
      pinv <= k == 0 ? 8'hFF : k == 1 ? 8'hFE : k == 2 ? 8'h7F : k == 3 ? 8'h00
              : 8'($random(seed));
      chan <= k[0];
      dfield <= k[1:0];
      rst_b <= 1'h0;
      repeat (3) @(posedge clk);
      rst_b <= 1'h1;
      for (n = 0; n < 10; n++) begin
        @(posedge clk);
        if (valid === 1'h1) break;
      end
      if (n == 10) timeout();
      e_word = word;
      cnt = 255 - pinv;
      chk_dec();
      rd_chk(16'hF200, 32'h0000_0008);
      d = $random(seed);
      bus(1'h1, 16'hF200, d, 4'hF, rv);
      rd_chk(16'hF200, d & 32'h0000_000D);
      cmp_ctl({13'h0, scan, trace, sdo}, {13'h0, d[3], d[2], d[0]});
      key = $random(seed);
      kb = 4'($random(seed));
      ek = 32'h0;
      for (n = 0; n < 4; n++) if (kb[n]) ek[n*8+:8] = key[n*8+:8];
      rd_chk(16'hF230, 32'h0);
      bus(1'h1, 16'hF230, key, kb, rv);
      rd_chk(16'hF230, ek);
      bus(1'h1, 16'hF220, key, 4'hF, rv);
      rd_chk(16'hF220, {REV, PID});
      bus(1'h1, 16'hF240, key, 4'hF, rv);
      rd_chk(16'hF240, e_word);
      bus(1'h1, 16'hF210, key, 4'hF, rv);
      rd_chk(16'hF210, 32'h0);
      prog_chk();
      fwr(1'h1, 8'($random(seed)), e_word[24]);
      if (cnt > 0) fwr(1'h0, 8'(cnt - 1), 1'h0);
      fwr(1'h0, 8'(cnt), 1'h1);
      pg = $random(seed) & 255;
      fwr(1'h0, 8'(pg), pg >= cnt);
      // Word changes under a running device must not reach the decoded controls
      @(posedge clk);
      {lock_n, boot_n, chan} <= 3'($random(seed));
      pinv <= ~pinv;
      dfield <= ~dfield;
      repeat (3) @(posedge clk);
      chk_dec();
      prog_chk();
    end
    report_and_stop();
  end
endmodule
